/* design/jtp_cfg.svh */
`ifndef JTP_CFG_SVH
`define JTP_CFG_SVH

// ----------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------
`define JTP_IR_W            4
`define JTP_IR_RESET        4'hF
`define JTP_IR_CAPTURE      4'h1
`define JTP_OP_EXTEST       4'h0
`define JTP_OP_CLAMP        4'h1
`define JTP_OP_SAMPLE       4'h2
`define JTP_OP_SELF_TEST    4'h3
`define JTP_OP_EMULATION    4'h6

// ----------------------------------------------------------------------
// data registers
// ----------------------------------------------------------------------
`define JTP_BSR_LEN         173
`define JTP_ST_W            8
// cell n of the chain sits at vector index n-1, index 0 next to tdo
`define JTP_LOW_BYTE_CELL   22
`define JTP_HIGH_BYTE_CELL  42

// ----------------------------------------------------------------------
// pin filter
// ----------------------------------------------------------------------
`define JTP_SYNC_STAGES     3

`endif

/* design/jtp_pkg.sv */
package jtp_pkg;

    typedef enum logic [3:0] {
        TAP_RESET,
        TAP_IDLE,
        TAP_SEL_DR,
        TAP_CAP_DR,
        TAP_SHIFT_DR,
        TAP_EXIT1_DR,
        TAP_PAUSE_DR,
        TAP_EXIT2_DR,
        TAP_UPD_DR,
        TAP_SEL_IR,
        TAP_CAP_IR,
        TAP_SHIFT_IR,
        TAP_EXIT1_IR,
        TAP_PAUSE_IR,
        TAP_EXIT2_IR,
        TAP_UPD_IR
    } jtp_tap_state_e;

    typedef enum logic [1:0] {
        PATH_BYPASS,
        PATH_BOUNDARY,
        PATH_SELF_TEST
    } jtp_path_e;

endpackage

/* design/jtp_pin_filter.sv */
`timescale 1ns/1ns
`include "jtp_cfg.svh"

// three-stage synchroniser: the filtered level moves only once the
// second and third stages agree, so a single metastable sample is dropped
module jtp_pin_filter (
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    input  wire logic pin_i,
    input  wire logic init_i,
    output logic      level_o
);

    logic [`JTP_SYNC_STAGES-1:0] stage_reg;
    logic                        level_reg;
    logic                        level_next;

    assign level_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : level_reg;
    assign level_o    = level_reg;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            stage_reg <= {`JTP_SYNC_STAGES{init_i}};
            level_reg <= init_i;
        end else begin
            stage_reg <= {stage_reg[1:0], pin_i};
            level_reg <= level_next;
        end
    end

endmodule

/* design/jtp_tap.sv */
`timescale 1ns/1ns
`include "jtp_cfg.svh"

// Functional notes
// - standard TAP state machine, IR and DR scanning
// - port works only while enable is high
// - enable, tck, tms, tdi in; tdo out
// - four scan registers, instruction picks path
// - instruction register is four bits
// - decode extest, clamp, sample, self-test, emulation
// - codes 1xxx are bypass, normal mode; 1111 default
// - codes 01xx scan through bypass register
// - extest forces loaded pin and input values
// - clamp drives chain onto pads, scans bypass
// - clamp feeds core inputs from the chain
// - sample/preload captures pins, shifts new values
// - cells follow normal-mode pin directions
// - bidir cell 0 drives; tristate cell 1 floats
// - re-enable resets logic, bypass, normal mode
// - self-test raises nmi, scans 8-bit result
module jtp_tap (
    input  wire logic                    clk_sys_i,
    input  wire logic                    sys_rst_i,
    input  wire logic                    test_port_enable_i,
    input  wire logic                    tck_i,
    input  wire logic                    tms_i,
    input  wire logic                    tdi_i,
    output logic                         tdo_o,
    output logic                         tdo_oe_o,
    output logic                         pins_released_o,
    input  wire logic [`JTP_BSR_LEN-1:0] bsr_capture_i,
    output logic      [`JTP_BSR_LEN-1:0] bsr_update_o,
    output logic                         pads_from_chain_o,
    output logic                         core_from_chain_o,
    output logic                         low_byte_drive_o,
    output logic                         high_byte_drive_o,
    input  wire logic [`JTP_ST_W-1:0]    self_test_result_i,
    output logic                         self_test_nmi_o,
    output logic                         emulation_mode_o,
    output logic [`JTP_IR_W-1:0]         instruction_o
);

    // ------------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------------
    function automatic jtp_pkg::jtp_path_e path_of(input logic [`JTP_IR_W-1:0] op);
        jtp_pkg::jtp_path_e p;
        p = jtp_pkg::PATH_BYPASS;
        if (op == `JTP_OP_EXTEST || op == `JTP_OP_SAMPLE) begin
            p = jtp_pkg::PATH_BOUNDARY;
        end else if (op == `JTP_OP_SELF_TEST) begin
            p = jtp_pkg::PATH_SELF_TEST;
        end
        return p;
    endfunction

    // bidirectional control cell: 0 drives; tristate control cell: 1 floats
    function automatic logic cell_drives(input logic value, input logic is_tristate);
        return is_tristate ? ~value : ~value;
    endfunction

    // ------------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------------
    localparam int NPIN = 4;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_lvl;
    assign pin_raw = {test_port_enable_i, tck_i, tms_i, tdi_i};
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            jtp_pin_filter u_filter (
                .clk_sys_i (clk_sys_i),
                .sys_rst_i (sys_rst_i),
                .pin_i     (pin_raw[gi]),
                .init_i    (1'b0),
                .level_o   (pin_lvl[gi])
            );
        end
    endgenerate
    logic en_lvl;
    logic tck_lvl;
    logic tms_lvl;
    logic tdi_lvl;
    assign en_lvl  = pin_lvl[3];
    assign tck_lvl = pin_lvl[2];
    assign tms_lvl = pin_lvl[1];
    assign tdi_lvl = pin_lvl[0];
    logic tck_q_reg;
    logic en_q_reg;
    logic tck_rise;
    logic tck_fall;
    logic port_reset;
    // an undriven enable reads low through the pad pull-down, so the port idles off
    assign tck_rise   = en_lvl & tck_lvl & ~tck_q_reg;
    assign tck_fall   = en_lvl & ~tck_lvl & tck_q_reg;
    assign port_reset = ~en_lvl | (en_lvl & ~en_q_reg);

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            tck_q_reg <= 1'b0;
            en_q_reg  <= 1'b0;
        end else begin
            tck_q_reg <= tck_lvl;
            en_q_reg  <= en_lvl;
        end
    end

    // ------------------------------------------------------------------
    // tap controller
    // ------------------------------------------------------------------
    jtp_pkg::jtp_tap_state_e state_reg;
    jtp_pkg::jtp_tap_state_e state_next;
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            jtp_pkg::TAP_RESET:    state_next = tms_lvl ? jtp_pkg::TAP_RESET
                                                        : jtp_pkg::TAP_IDLE;
            jtp_pkg::TAP_IDLE:     state_next = tms_lvl ? jtp_pkg::TAP_SEL_DR
                                                        : jtp_pkg::TAP_IDLE;
            jtp_pkg::TAP_SEL_DR:   state_next = tms_lvl ? jtp_pkg::TAP_SEL_IR
                                                        : jtp_pkg::TAP_CAP_DR;
            jtp_pkg::TAP_CAP_DR:   state_next = tms_lvl ? jtp_pkg::TAP_EXIT1_DR
                                                        : jtp_pkg::TAP_SHIFT_DR;
            jtp_pkg::TAP_SHIFT_DR: state_next = tms_lvl ? jtp_pkg::TAP_EXIT1_DR
                                                        : jtp_pkg::TAP_SHIFT_DR;
            jtp_pkg::TAP_EXIT1_DR: state_next = tms_lvl ? jtp_pkg::TAP_UPD_DR
                                                        : jtp_pkg::TAP_PAUSE_DR;
            jtp_pkg::TAP_PAUSE_DR: state_next = tms_lvl ? jtp_pkg::TAP_EXIT2_DR
                                                        : jtp_pkg::TAP_PAUSE_DR;
            jtp_pkg::TAP_EXIT2_DR: state_next = tms_lvl ? jtp_pkg::TAP_UPD_DR
                                                        : jtp_pkg::TAP_SHIFT_DR;
            jtp_pkg::TAP_UPD_DR:   state_next = tms_lvl ? jtp_pkg::TAP_SEL_DR
                                                        : jtp_pkg::TAP_IDLE;
            jtp_pkg::TAP_SEL_IR:   state_next = tms_lvl ? jtp_pkg::TAP_RESET
                                                        : jtp_pkg::TAP_CAP_IR;
            jtp_pkg::TAP_CAP_IR:   state_next = tms_lvl ? jtp_pkg::TAP_EXIT1_IR
                                                        : jtp_pkg::TAP_SHIFT_IR;
            jtp_pkg::TAP_SHIFT_IR: state_next = tms_lvl ? jtp_pkg::TAP_EXIT1_IR
                                                        : jtp_pkg::TAP_SHIFT_IR;
            jtp_pkg::TAP_EXIT1_IR: state_next = tms_lvl ? jtp_pkg::TAP_UPD_IR
                                                        : jtp_pkg::TAP_PAUSE_IR;
            jtp_pkg::TAP_PAUSE_IR: state_next = tms_lvl ? jtp_pkg::TAP_EXIT2_IR
                                                        : jtp_pkg::TAP_PAUSE_IR;
            jtp_pkg::TAP_EXIT2_IR: state_next = tms_lvl ? jtp_pkg::TAP_UPD_IR
                                                        : jtp_pkg::TAP_SHIFT_IR;
            jtp_pkg::TAP_UPD_IR:   state_next = tms_lvl ? jtp_pkg::TAP_SEL_DR
                                                        : jtp_pkg::TAP_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || port_reset) begin
            state_reg <= jtp_pkg::TAP_RESET;
        end else if (tck_rise) begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // state strobes, all but in_reset qualified by a tck rising edge
    // ------------------------------------------------------------------
    logic cap_ir;
    logic shift_ir;
    logic upd_ir;
    logic cap_dr;
    logic shift_dr;
    logic upd_dr;
    logic in_reset;
    assign cap_ir   = tck_rise & (state_reg == jtp_pkg::TAP_CAP_IR);
    assign shift_ir = tck_rise & (state_reg == jtp_pkg::TAP_SHIFT_IR);
    assign upd_ir   = tck_rise & (state_reg == jtp_pkg::TAP_UPD_IR);
    assign cap_dr   = tck_rise & (state_reg == jtp_pkg::TAP_CAP_DR);
    assign shift_dr = tck_rise & (state_reg == jtp_pkg::TAP_SHIFT_DR);
    assign upd_dr   = tck_rise & (state_reg == jtp_pkg::TAP_UPD_DR);
    assign in_reset = port_reset | (state_reg == jtp_pkg::TAP_RESET);

    // ------------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------------
    logic [`JTP_IR_W-1:0] ir_shift_reg;
    logic [`JTP_IR_W-1:0] ir_reg;
    logic [`JTP_IR_W-1:0] ir_shift_next;
    assign ir_shift_next = cap_ir   ? `JTP_IR_CAPTURE :
                           shift_ir ? {tdi_lvl, ir_shift_reg[`JTP_IR_W-1:1]} :
                           ir_shift_reg;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || in_reset) begin
            ir_shift_reg <= `JTP_IR_RESET;
            ir_reg       <= `JTP_IR_RESET;
        end else begin
            ir_shift_reg <= ir_shift_next;
            if (upd_ir) begin
                ir_reg <= ir_shift_reg;
            end
        end
    end

    // ------------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------------
    jtp_pkg::jtp_path_e path_sel;
    logic               op_extest;
    logic               op_clamp;
    logic               op_upd_bsr;
    logic               new_self_test;
    logic               new_emulation;
    logic               new_normal;
    assign path_sel      = path_of(ir_reg);
    assign op_extest     = (ir_reg == `JTP_OP_EXTEST);
    assign op_clamp      = (ir_reg == `JTP_OP_CLAMP);
    assign op_upd_bsr    = (path_sel == jtp_pkg::PATH_BOUNDARY);
    assign new_self_test = upd_ir & (ir_shift_reg == `JTP_OP_SELF_TEST);
    assign new_emulation = upd_ir & (ir_shift_reg == `JTP_OP_EMULATION);
    assign new_normal    = upd_ir & ir_shift_reg[`JTP_IR_W-1];

    // ------------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------------
    logic                    bypass_reg;
    logic [`JTP_ST_W-1:0]    st_shift_reg;
    logic [`JTP_BSR_LEN-1:0] bsr_shift_reg;
    logic [`JTP_BSR_LEN-1:0] bsr_upd_reg;
    logic                    shift_bypass;
    logic                    shift_st;
    logic                    shift_bsr;
    assign shift_bypass = shift_dr & (path_sel == jtp_pkg::PATH_BYPASS);
    assign shift_st     = shift_dr & (path_sel == jtp_pkg::PATH_SELF_TEST);
    assign shift_bsr    = shift_dr & op_upd_bsr;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || in_reset) begin
            bypass_reg <= 1'b0;
        end else if (cap_dr) begin
            bypass_reg <= 1'b0;
        end else if (shift_bypass) begin
            bypass_reg <= tdi_lvl;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || in_reset) begin
            st_shift_reg <= '0;
        end else if (cap_dr && path_sel == jtp_pkg::PATH_SELF_TEST) begin
            st_shift_reg <= self_test_result_i;
        end else if (shift_st) begin
            st_shift_reg <= {tdi_lvl, st_shift_reg[`JTP_ST_W-1:1]};
        end
    end

    // cell 1 at index 0 leaves first on tdo, the highest cell enters from tdi
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            bsr_shift_reg <= '0;
        end else if (cap_dr && op_upd_bsr) begin
            bsr_shift_reg <= bsr_capture_i;
        end else if (shift_bsr) begin
            bsr_shift_reg <= {tdi_lvl, bsr_shift_reg[`JTP_BSR_LEN-1:1]};
        end
    end

    // the update latch keeps its contents across test reset so a preloaded
    // pattern survives; it drives bsr_update_o and both byte drive outputs under every instruction
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            bsr_upd_reg <= '0;
        end else if (upd_dr && op_upd_bsr) begin
            bsr_upd_reg <= bsr_shift_reg;
        end
    end

    // ------------------------------------------------------------------
    // mode and self-test side effects
    // ------------------------------------------------------------------
    logic emulation_reg;
    logic nmi_reg;
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || in_reset) begin
            emulation_reg <= 1'b0;
            nmi_reg       <= 1'b0;
        end else begin
            nmi_reg <= new_self_test;
            if (new_emulation) begin
                emulation_reg <= 1'b1;
            end else if (new_normal) begin
                emulation_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // tdo, changes on the falling tck edge
    // ------------------------------------------------------------------
    logic tdo_reg;
    logic tdo_oe_reg;
    logic scan_bit;
    logic shifting;
    assign shifting = (state_reg == jtp_pkg::TAP_SHIFT_DR)
                    | (state_reg == jtp_pkg::TAP_SHIFT_IR);
    assign scan_bit = (state_reg == jtp_pkg::TAP_SHIFT_IR)      ? ir_shift_reg[0] :
                      (path_sel == jtp_pkg::PATH_BOUNDARY)      ? bsr_shift_reg[0] :
                      (path_sel == jtp_pkg::PATH_SELF_TEST)     ? st_shift_reg[0] :
                      bypass_reg;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || port_reset) begin
            tdo_reg    <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end else if (tck_fall) begin
            tdo_reg    <= shifting ? scan_bit : 1'b0;
            tdo_oe_reg <= shifting;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic drive_chain;
    assign drive_chain = op_extest | op_clamp;
    assign tdo_o             = tdo_reg;
    assign tdo_oe_o          = tdo_oe_reg;
    assign pins_released_o   = ~en_lvl;
    assign bsr_update_o      = bsr_upd_reg;
    assign pads_from_chain_o = drive_chain;
    assign core_from_chain_o = drive_chain;
    // one direction cell per data byte; only normal-mode cells exist
    assign low_byte_drive_o  = cell_drives(bsr_upd_reg[`JTP_LOW_BYTE_CELL], 1'b0);
    assign high_byte_drive_o = cell_drives(bsr_upd_reg[`JTP_HIGH_BYTE_CELL], 1'b0);
    assign self_test_nmi_o   = nmi_reg;
    assign emulation_mode_o  = emulation_reg;
    assign instruction_o     = ir_reg;

endmodule

/* sim/jtp_tap_monitor.sv */
`timescale 1ns/1ns
`include "jtp_cfg.svh"

module jtp_tap_monitor (
    input  wire logic                    clk_sys_i,
    input  wire logic                    sys_rst_i,
    input  wire logic                    test_port_enable_i,
    input  wire logic                    tdo_o,
    input  wire logic                    tdo_oe_o,
    input  wire logic                    pins_released_o,
    input  wire logic [`JTP_BSR_LEN-1:0] bsr_update_o,
    input  wire logic                    pads_from_chain_o,
    input  wire logic                    core_from_chain_o,
    input  wire logic                    low_byte_drive_o,
    input  wire logic                    high_byte_drive_o,
    input  wire logic                    self_test_nmi_o,
    input  wire logic                    emulation_mode_o,
    input  wire logic [`JTP_IR_W-1:0]    instruction_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    sequence s_port_off;
        !test_port_enable_i [*6];
    endsequence
    sequence s_nmi_pulse;
        self_test_nmi_o ##1 !self_test_nmi_o;
    endsequence
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_released_when_off: assert property (s_port_off |-> pins_released_o)
        else $error("pins not released");
    a_tdo_off_released: assert property (pins_released_o [*2] |-> !tdo_oe_o)
        else $error("tdo driven while released");
    a_ir_default: assert property ($fell(sys_rst_i) |-> instruction_o == 4'hF)
        else $error("instruction not default after reset");
    a_held_test_reset: assert property (pins_released_o [*2] |->
        instruction_o == 4'hF && !emulation_mode_o)
        else $error("test logic not reset while disabled");
    a_pads_decode: assert property (pads_from_chain_o == (instruction_o[3:1] == 3'h0))
        else $error("pad source decode");
    a_core_decode: assert property (core_from_chain_o == (instruction_o[3:1] == 3'h0))
        else $error("core source decode");
    a_low_drive: assert property (low_byte_drive_o == !bsr_update_o[`JTP_LOW_BYTE_CELL])
        else $error("low byte direction");
    a_high_drive: assert property (high_byte_drive_o == !bsr_update_o[`JTP_HIGH_BYTE_CELL])
        else $error("high byte direction");
    a_nmi_pulse: assert property ($rose(self_test_nmi_o) |->
        instruction_o == 4'h3 ##0 s_nmi_pulse)
        else $error("nmi pulse");
    a_emul_cause: assert property ($rose(emulation_mode_o) |-> instruction_o == 4'h6)
        else $error("emulation without its code");
    a_bypass_normal: assert property (instruction_o[3] [*2] |-> !emulation_mode_o)
        else $error("bypass code left emulation on");
    a_tdo_quiet: assert property (!tdo_oe_o |-> !tdo_o)
        else $error("tdo not low outside shift");
endmodule

bind jtp_tap jtp_tap_monitor mon_u (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .test_port_enable_i(test_port_enable_i),
    .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pins_released_o(pins_released_o),
    .bsr_update_o(bsr_update_o), .pads_from_chain_o(pads_from_chain_o),
    .core_from_chain_o(core_from_chain_o), .low_byte_drive_o(low_byte_drive_o),
    .high_byte_drive_o(high_byte_drive_o), .self_test_nmi_o(self_test_nmi_o),
    .emulation_mode_o(emulation_mode_o), .instruction_o(instruction_o)
);

/* sim/jtp_ctrl_model.sv */
`timescale 1ns/1ns

// scan controller; tck stands low between frames, tms/tdi move only at tck fall
module jtp_ctrl_model (
    input  wire logic clk_sys_i,
    input  wire logic tdo_i,
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    // 4 system clocks a half: 320 ns period, under the tck ceiling
    task automatic cyc(input logic tms, input logic tdi, output logic tdo);
        tck_o = 1'b0;
        tms_o = tms;
        tdi_o = tdi;
        repeat (4) @(negedge clk_sys_i);
        tck_o = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        // tdo stands until the coming fall, so sample late in the high phase
        tdo = tdo_i;
    endtask
    task automatic tap_reset();
        logic b;
        repeat (5) cyc(1'b1, 1'b0, b);
        cyc(1'b0, 1'b0, b);
        tck_o = 1'b0;
    endtask
    // from idle to idle; data goes lsb first
    task automatic scan(input logic ir, input int n, input logic [172:0] din,
                        output logic [172:0] dout);
        logic b;
        dout = '0;
        cyc(1'b1, 1'b0, b);
        if (ir) cyc(1'b1, 1'b0, b);
        cyc(1'b0, 1'b0, b);
        cyc(1'b0, 1'b0, b);
        for (int k = 0; k < n; k++) begin
            cyc(k == n - 1, din[k], b);
            dout[k] = b;
        end
        cyc(1'b1, 1'b0, b);
        cyc(1'b0, 1'b0, b);
        tck_o = 1'b0;
        // the pin filters delay the last rising edge by about four clocks, so
        // the update it carries is only visible after this wait
        repeat (4) @(negedge clk_sys_i);
    endtask
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ns
`include "jtp_cfg.svh"
`define CHK(act, exp, msg) begin samples_checked++; if ((act) !== (exp)) begin \
    fail_count++; $display("wrong value at %0t: %s", $time, msg); end end

module tb_top;
    logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, test_port_enable_i = 1'b0;
    logic tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, pins_released_o;
    logic pads_from_chain_o, core_from_chain_o, low_byte_drive_o, high_byte_drive_o;
    logic self_test_nmi_o, emulation_mode_o;
    logic [3:0]   instruction_o, c;
    logic [7:0]   self_test_result_i = 8'h00;
    logic [172:0] bsr_capture_i = '0, bsr_update_o, din, dout, upd_exp = '0;
    logic [191:0] rnd;
    logic [3:0]   codes [16] = '{8, 9, 10, 11, 12, 13, 14, 15, 4, 5, 7, 2, 1, 0, 3, 6};
    logic         emu_exp = 1'b0;
    int           fail_count = 0, samples_checked = 0, nmi_count = 0, n0;
    int           seed = 32'hc9e6;

    always #20 clk_sys_i = ~clk_sys_i;
    always @(negedge clk_sys_i) if (self_test_nmi_o === 1'b1) nmi_count++;

    jtp_tap dut_u (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .test_port_enable_i(test_port_enable_i),
        .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
        .pins_released_o(pins_released_o), .bsr_capture_i(bsr_capture_i),
        .bsr_update_o(bsr_update_o), .pads_from_chain_o(pads_from_chain_o),
        .core_from_chain_o(core_from_chain_o), .low_byte_drive_o(low_byte_drive_o),
        .high_byte_drive_o(high_byte_drive_o), .self_test_result_i(self_test_result_i),
        .self_test_nmi_o(self_test_nmi_o), .emulation_mode_o(emulation_mode_o),
        .instruction_o(instruction_o)
    );
    jtp_ctrl_model ctrl_u (.clk_sys_i(clk_sys_i), .tdo_i(tdo_o), .tck_o(tck_i),
        .tms_o(tms_i), .tdi_o(tdi_i));

    // scan path length follows the instruction: boundary, self-test or bypass
    function automatic logic [172:0] exp_out(input logic [3:0] code, input logic [172:0] d,
                                             input logic [172:0] cap, input logic [7:0] r);
        if (code == `JTP_OP_EXTEST || code == `JTP_OP_SAMPLE) return cap;
        if (code == `JTP_OP_SELF_TEST) return {d[164:0], r};
        return {d[171:0], 1'b0};
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i) sys_rst_i = 1'b0;
        `CHK(pins_released_o, 1'b1, "pins held while disabled")
        ctrl_u.scan(1'b1, 4, 173'h0, dout);
        `CHK(instruction_o, `JTP_IR_RESET, "disabled port took a load")
        `CHK(tdo_oe_o, 1'b0, "tdo driven while disabled")
        test_port_enable_i = 1'b1;
        repeat (10) @(negedge clk_sys_i);
        `CHK(pins_released_o, 1'b0, "port not enabled")
        ctrl_u.tap_reset();
        // preload before clamp, 00xx codes before the emulation switch
        // the core reset that must span a mode switch lies outside this block
        for (int i = 0; i < 16; i++) begin
            c = codes[i];
            rnd = {$random(seed), $random(seed), $random(seed),
                   $random(seed), $random(seed), $random(seed)};
            bsr_capture_i = rnd[172:0];
            self_test_result_i = rnd[191:184];
            rnd = {$random(seed), $random(seed), $random(seed),
                   $random(seed), $random(seed), $random(seed)};
            din = (i == 12) ? 173'h0 : rnd[172:0];
            n0 = nmi_count;
            ctrl_u.scan(1'b1, 4, {169'h0, c}, dout);
            emu_exp = (c == `JTP_OP_EMULATION) ? 1'b1 : (c[3] ? 1'b0 : emu_exp);
            `CHK(dout[3:0], `JTP_IR_CAPTURE, "ir capture")
            `CHK(instruction_o, c, "instruction")
            `CHK(emulation_mode_o, emu_exp, "mode select")
            `CHK(nmi_count - n0, (c == `JTP_OP_SELF_TEST) ? 1 : 0, "nmi count")
            `CHK(pads_from_chain_o, c[3:1] == 3'h0, "pads source")
            `CHK(core_from_chain_o, c[3:1] == 3'h0, "core source")
            upd_exp = (c == `JTP_OP_EXTEST || c == `JTP_OP_SAMPLE) ? din : upd_exp;
            ctrl_u.scan(1'b0, 173, din, dout);
            `CHK(dout, exp_out(c, din, bsr_capture_i, self_test_result_i), "scan out")
            `CHK(bsr_update_o, upd_exp, "update latch")
            `CHK(low_byte_drive_o, ~upd_exp[22], "low byte drive")
            `CHK(high_byte_drive_o, ~upd_exp[42], "high byte drive")
            $display("test code %h done", c);
        end
        test_port_enable_i = 1'b0;
        repeat (10) @(negedge clk_sys_i);
        `CHK(pins_released_o, 1'b1, "pins not released")
        `CHK(emulation_mode_o, 1'b0, "mode kept over disable")
        test_port_enable_i = 1'b1;
        repeat (10) @(negedge clk_sys_i);
        `CHK(instruction_o, `JTP_IR_RESET, "not bypass after enable")
        $display("test re-enable done");
        print_verdict();
    end
endmodule
